// *** hdl/rsu_ctrl.sv ***
// remote upgrade control with user watchdog: update, control and
// status registers, image selection on triggers and errors.
// assumes i_clk is the 10 MHz internal oscillator, fabric requests are
// on i_clk, and the two device pins are asynchronous.
// a status pin held low restarts the load each cycle
`timescale 1ns/1ns
`include "rsu_regs.svh"

module rsu_ctrl (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_core_reconfig_request,
    input wire logic i_watchdog_reload_request,
    input wire logic i_external_reconfig_pin_n,
    input wire logic i_config_status_pin_n,
    input wire logic i_crc_error,
    input wire logic i_config_done,
    output logic o_reconfig_start,
    output logic o_load_app,
    output logic [23:0] o_boot_addr,
    output logic o_early_done_option,
    output logic o_osc_int_option,
    output logic [1:0] o_mode,
    output logic o_watchdog_timeout,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////
    // state

    localparam logic [`RSU_REQ_CW-1:0] REQ_CYC = `RSU_REQ_CW'(`RSU_REQ_CYC);

    typedef struct packed {
        rsu_pkg::rsu_mode_t mode;
        logic tgt_app;
        rsu_pkg::rsu_img_t upd;
        rsu_pkg::rsu_img_t ctl;
        logic [`RSU_SRC_W-1:0] src;
        logic [`RSU_SRC_W-1:0] evt;
        logic [`RSU_SRC_W-1:0] mask;
        logic [1:0][`RSU_REQ_CW-1:0] hold;
        logic [1:0] done;
        logic ext_prev;
        logic start;
        logic wd_to;
        logic [31:0] rdata;
    } rsu_st_t;

    // all state in one record; d is the next value
    rsu_st_t q, d;

    logic [1:0] pins_s;
    logic [1:0] req;
    logic [1:0] req_fire;
    logic wd_run;
    logic wd_expire;
    logic [`RSU_WD_W-1:0] wd_init;
    logic [`RSU_WD_W-1:0] wd_count;
    logic [`RSU_SRC_W-1:0] hit;
    logic [`RSU_SRC_W-1:0] src_1h;
    logic [1:0] st_code;
    logic [31:0] status_word;
    logic [31:0] cfg_upd;
    logic [31:0] cfg_ctl;
    logic [1:0] pin_raw;
    logic ext_fall;
    logic sts_low;
    logic core_ok;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; both pins idle high
    // bit 0 external pin, bit 1 status pin
    assign pin_raw = {i_config_status_pin_n, i_external_reconfig_pin_n};

    rsu_sync #(
        .W(2),
        .RST(2'h3)
    ) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(pin_raw),
        .o_q(pins_s)
    );

    ////////////////////////////////////////////////////////////////////
    // watchdog

    // the low 17 bits are fixed, so settings step by 2^17 cycles
    assign wd_init = {q.ctl.wdv, `RSU_WD_LOW};
    // runs only in application user mode and only if the image enables it
    assign wd_run = (q.mode == rsu_pkg::RSU_APP) && q.ctl.wden;

    // time follows the oscillator, which may run slow
    // outside the application the count holds the setting
    // expiry is one pulse; the trigger logic reacts to it
    rsu_wdog #(
        .W(`RSU_WD_W)
    ) u_wdog (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_run(wd_run),
        .i_reload(req_fire[1]),
        .i_init(wd_init),
        .o_expire(wd_expire),
        .o_count(wd_count)
    );

    ////////////////////////////////////////////////////////////////////
    // request hold filters: a request acts once, after 250 ns held high

    // bit 0 core request, bit 1 watchdog reload
    assign req = {i_watchdog_reload_request, i_core_reconfig_request};

    // shorter pulses never act; a held request acts only once
    // counted in i_clk cycles, so it scales with the clock
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_req
            assign req_fire[gi] = req[gi] && !q.done[gi]
                && (q.hold[gi] == REQ_CYC - 1'b1);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // trigger sources, one-hot with the higher bit winning a tie

    // edge memory resets high, so reset is no edge
    assign ext_fall = q.ext_prev && !pins_s[0];
    // a level: a stuck-low pin keeps it configuring
    assign sts_low = !pins_s[1];
    // core requests only count once an image is running
    assign core_ok = req_fire[0] && (q.mode != rsu_pkg::RSU_CONFIG);

    always_comb begin
        hit = '0;
        hit[`RSU_SRC_EXT] = ext_fall;
        hit[`RSU_SRC_CRC] = i_crc_error;
        hit[`RSU_SRC_STS] = sts_low;
        hit[`RSU_SRC_WD] = wd_expire;
        hit[`RSU_SRC_CORE] = core_ok;
        // fixed priority keeps the cause one-hot
        src_1h = '0;
        if (hit[`RSU_SRC_EXT]) begin
            src_1h[`RSU_SRC_EXT] = 1'b1;
        end else if (hit[`RSU_SRC_CRC]) begin
            src_1h[`RSU_SRC_CRC] = 1'b1;
        end else if (hit[`RSU_SRC_STS]) begin
            src_1h[`RSU_SRC_STS] = 1'b1;
        end else if (hit[`RSU_SRC_WD]) begin
            src_1h[`RSU_SRC_WD] = 1'b1;
        end else if (hit[`RSU_SRC_CORE]) begin
            src_1h[`RSU_SRC_CORE] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read views

    always_comb begin
        // the setting is shown; the live count has its own view
        unique case (q.mode)
            rsu_pkg::RSU_FACTORY: st_code = `RSU_ST_FACTORY;
            rsu_pkg::RSU_APP: st_code = `RSU_ST_APP;
            default: st_code = `RSU_ST_CONFIG;
        endcase
        status_word = '0;
        status_word[`RSU_F_STATE_HI:`RSU_F_STATE_LO] = st_code;
        if (q.mode == rsu_pkg::RSU_APP) begin
            status_word[`RSU_F_ST_WDEN] = q.ctl.wden;
            status_word[`RSU_WD_W-1:0] = wd_init;
        end else begin
            status_word[`RSU_ADDR_W-1:0] = q.ctl.addr;
        end
    end

    // the same packing serves both registers
    // fields outside the layout read as zero
    always_comb begin
        cfg_upd = '0;
        cfg_upd[`RSU_F_EARLY] = q.upd.early;
        cfg_upd[`RSU_F_OSC] = q.upd.osc;
        cfg_upd[`RSU_F_WDEN] = q.upd.wden;
        cfg_upd[`RSU_F_WDV_HI:`RSU_F_WDV_LO] = q.upd.wdv;
        cfg_ctl = '0;
        cfg_ctl[`RSU_F_EARLY] = q.ctl.early;
        cfg_ctl[`RSU_F_OSC] = q.ctl.osc;
        cfg_ctl[`RSU_F_WDEN] = q.ctl.wden;
        cfg_ctl[`RSU_F_WDV_HI:`RSU_F_WDV_LO] = q.ctl.wdv;
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        // pulses end unless this cycle raises them again
        d.start = 1'b0;
        d.wd_to = wd_expire;
        // edge memory for the external pin
        d.ext_prev = pins_s[0];
        d.rdata = '0;

        // hold counters saturate one below the filter length
        // a low cycle clears the count and rearms it
        for (int i = 0; i < 2; i++) begin
            if (!req[i]) begin
                d.hold[i] = '0;
                d.done[i] = 1'b0;
            end else if (q.hold[i] != REQ_CYC - 1'b1) begin
                d.hold[i] = q.hold[i] + 1'b1;
            end
            if (req_fire[i]) begin
                d.done[i] = 1'b1;
            end
        end

        // software writes; the update register only in factory mode
        if (i_wr) begin
            unique case (i_addr)
                `RSU_OFF_UPD_CFG: begin
                    if (q.mode == rsu_pkg::RSU_FACTORY) begin
                        d.upd.early = i_wdata[`RSU_F_EARLY];
                        d.upd.osc = i_wdata[`RSU_F_OSC];
                        d.upd.wden = i_wdata[`RSU_F_WDEN];
                        d.upd.wdv = i_wdata[`RSU_F_WDV_HI:`RSU_F_WDV_LO];
                    end
                end
                `RSU_OFF_UPD_ADDR: begin
                    if (q.mode == rsu_pkg::RSU_FACTORY) begin
                        d.upd.addr = i_wdata[`RSU_ADDR_W-1:0];
                    end
                end
                `RSU_OFF_EVT: d.evt = q.evt & ~i_wdata[`RSU_SRC_W-1:0];
                `RSU_OFF_MASK: d.mask = i_wdata[`RSU_SRC_W-1:0];
                // read-only views ignore writes
                default: ;
            endcase
        end

        // new events win over a clear in the same cycle
        // so an event landing on a clear is kept
        d.evt = d.evt | hit;

        // trigger handling; only this path writes the control register
        // an error while configuring restarts the factory load
        if (src_1h != '0) begin
            d.mode = rsu_pkg::RSU_CONFIG;
            d.start = 1'b1;
            // error monitor records the cause before the reload
            d.src = src_1h;
            if (src_1h[`RSU_SRC_CORE] && q.mode == rsu_pkg::RSU_FACTORY) begin
                d.ctl = q.upd;
                d.tgt_app = 1'b1;
            end else if (src_1h[`RSU_SRC_CORE]) begin
                // from an application, core requests fall back to factory
                d.tgt_app = 1'b0;
            end else begin
                // errors clear control: factory image next
                d.ctl = '0;
                d.tgt_app = 1'b0;
            end
        end else if (q.mode == rsu_pkg::RSU_CONFIG && i_config_done) begin
            // user mode is entered only when the engine says so
            d.mode = q.tgt_app ? rsu_pkg::RSU_APP : rsu_pkg::RSU_FACTORY;
        end

        // read data appear in the cycle after the strobe
        // unmapped addresses read as zero
        if (i_rd) begin
            unique case (i_addr)
                `RSU_OFF_UPD_CFG: d.rdata = cfg_upd;
                `RSU_OFF_UPD_ADDR: d.rdata = 32'(q.upd.addr);
                `RSU_OFF_CTL_CFG: d.rdata = cfg_ctl;
                `RSU_OFF_CTL_ADDR: d.rdata = 32'(q.ctl.addr);
                `RSU_OFF_STATUS: d.rdata = status_word;
                `RSU_OFF_SOURCE: d.rdata = 32'(q.src);
                `RSU_OFF_EVT: d.rdata = 32'(q.evt);
                `RSU_OFF_MASK: d.rdata = 32'(q.mask);
                `RSU_OFF_WD_COUNT: d.rdata = 32'(wd_count);
                default: d.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers; after reset the factory image is being loaded
    // the engine ends that load with i_config_done

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q <= '0;
            q.mode <= rsu_pkg::RSU_CONFIG;
            q.upd.wden <= `RSU_WDEN_RST;
            q.ctl.wden <= `RSU_WDEN_RST;
            q.ext_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    // mode code and irq are one gate after the flip-flops
    assign o_rdata = q.rdata;
    assign o_reconfig_start = q.start;
    // stands until the next trigger
    assign o_load_app = q.tgt_app;
    assign o_boot_addr = q.ctl.addr;
    assign o_early_done_option = q.ctl.early;
    assign o_osc_int_option = q.ctl.osc;
    assign o_mode = st_code;
    assign o_watchdog_timeout = q.wd_to;
    // level interrupt while any unmasked sticky event is set
    assign o_irq = |(q.evt & q.mask);

endmodule

// *** hdl/rsu_pkg.sv ***
// types for the upgrade control block; its submodules do not use them
// assumes rsu_regs.svh is on the include path
`include "rsu_regs.svh"

package rsu_pkg;

    // operating mode of the device as the upgrade logic sees it
    typedef enum logic [1:0] {
        RSU_CONFIG,
        RSU_FACTORY,
        RSU_APP
    } rsu_mode_t;

    // one image setting; update and control registers use this layout
    typedef struct packed {
        logic early;
        logic osc;
        logic wden;
        logic [`RSU_WDV_W-1:0] wdv;
        logic [`RSU_ADDR_W-1:0] addr;
    } rsu_img_t;

endpackage

// *** hdl/rsu_regs.svh ***
// register offsets, field positions, reset values and timing counts
// for the upgrade control block; included by bare name, definitions only
`ifndef RSU_REGS_SVH
`define RSU_REGS_SVH

// register byte offsets on the plain register port
`define RSU_OFF_UPD_CFG 8'h00
`define RSU_OFF_UPD_ADDR 8'h04
`define RSU_OFF_CTL_CFG 8'h08
`define RSU_OFF_CTL_ADDR 8'h0c
`define RSU_OFF_STATUS 8'h10
`define RSU_OFF_SOURCE 8'h14
`define RSU_OFF_EVT 8'h18
`define RSU_OFF_MASK 8'h1c
`define RSU_OFF_WD_COUNT 8'h20

// image setting word layout, shared by update and control registers
`define RSU_F_EARLY 0
`define RSU_F_OSC 1
`define RSU_F_WDEN 2
`define RSU_F_WDV_LO 16
`define RSU_F_WDV_HI 27
`define RSU_WDV_W 12
`define RSU_ADDR_W 24

// status word fields
`define RSU_F_STATE_HI 31
`define RSU_F_STATE_LO 30
`define RSU_F_ST_WDEN 29
`define RSU_WD_W 29
`define RSU_WD_LOW_W 17
`define RSU_WD_LOW 17'h00008
`define RSU_ST_CONFIG 2'h0
`define RSU_ST_FACTORY 2'h1
`define RSU_ST_APP 2'h2

// one-hot reconfiguration source, higher bit wins a tie
`define RSU_SRC_W 5
`define RSU_SRC_EXT 4
`define RSU_SRC_CRC 3
`define RSU_SRC_STS 2
`define RSU_SRC_WD 1
`define RSU_SRC_CORE 0

// reset values: watchdog enabled by default for application images
`define RSU_WDEN_RST 1'b1

// request hold time, clock period, cycles rounded up
`define RSU_REQ_MIN_NS 250
`define RSU_CLK_NS 100
`define RSU_REQ_CYC ((`RSU_REQ_MIN_NS + `RSU_CLK_NS - 1) / `RSU_CLK_NS)
`define RSU_REQ_CW 2

`endif

// *** hdl/rsu_sync.sv ***
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to i_clk; reset value is a parameter
`timescale 1ns/1ns

module rsu_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST = '1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rsu_sync_st_t;

    rsu_sync_st_t q, d;

    // the first stage feeds only the second stage
    always_comb begin
        d = q;
        d.s1 = i_d;
        d.s2 = q.s1;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q <= {RST, RST};
        end else begin
            q <= d;
        end
    end

    assign o_q = q.s2;

endmodule

// *** hdl/rsu_wdog.sv ***
// user watchdog down-counter
// assumes i_run drops as soon as the device leaves application mode
`timescale 1ns/1ns

module rsu_wdog #(
    parameter int W = 29
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic i_reload,
    input wire logic [W-1:0] i_init,
    output logic o_expire,
    output logic [W-1:0] o_count
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic fired;
        logic expire;
    } rsu_wd_st_t;

    rsu_wd_st_t q, d;

    // counts only while running; stopped it keeps the initial value loaded
    always_comb begin
        d = q;
        d.expire = 1'b0;
        if (!i_run) begin
            d.cnt = i_init;
            d.fired = 1'b0;
        end else if (i_reload) begin
            d.cnt = i_init;
            d.fired = 1'b0;
        end else if (q.cnt == '0) begin
            // one pulse per expiry, the owner reconfigures on it
            d.expire = !q.fired;
            d.fired = 1'b1;
        end else begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_expire = q.expire;
    assign o_count = q.cnt;

endmodule

// *** verif/rsu_ctrl_properties.sv ***
// checker for the upgrade control block, bound to rsu_ctrl
// assumes one clock domain i_clk and the low-active sync reset i_nrst
`timescale 1ns/1ns
`include "rsu_regs.svh"
module rsu_ctrl_chk (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_core_reconfig_request,
    input wire logic i_watchdog_reload_request,
    input wire logic o_reconfig_start,
    input wire logic o_load_app,
    input wire logic [23:0] o_boot_addr,
    input wire logic o_early_done_option,
    input wire logic o_osc_int_option,
    input wire logic [1:0] o_mode,
    input wire logic o_watchdog_timeout
);
    logic [7:0] run_q;
    logic [7:0] run_d;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////////
    // cycles spent in application mode, saturating so it never wraps
    always_comb run_d = (o_mode != `RSU_ST_APP) ? 8'h00 : run_q + {7'h00, run_q != 8'hff};
    always_ff @(posedge i_clk) run_q <= i_nrst ? run_d : 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // request steps: three held cycles in the right mode
    sequence s_core_hold;
        (o_mode == `RSU_ST_FACTORY && i_core_reconfig_request) [*3];
    endsequence
    sequence s_reload_hold;
        (o_mode == `RSU_ST_APP && i_watchdog_reload_request) [*3];
    endsequence
    property p_core_fires;
        s_core_hold |=> o_reconfig_start && o_load_app;
    endproperty
    property p_start_needs_hold;
        o_reconfig_start && o_load_app |-> $past(i_core_reconfig_request)
            && $past(i_core_reconfig_request, 2) && $past(i_core_reconfig_request, 3);
    endproperty
    property p_error_clears;
        o_reconfig_start && !o_load_app && !$past(i_core_reconfig_request)
            |-> o_boot_addr == 24'h000000
            && !o_early_done_option && !o_osc_int_option;
    endproperty
    property p_timeout_start;
        o_watchdog_timeout |-> o_reconfig_start && !o_load_app && o_mode == `RSU_ST_CONFIG;
    endproperty
    property p_timeout_from_app;
        o_watchdog_timeout |-> $past(o_mode) == `RSU_ST_APP;
    endproperty
    // the shortest setting still gives eight counts before expiry
    property p_timeout_min_count;
        o_watchdog_timeout |-> run_q >= 8'h08;
    endproperty
    property p_reload_holds;
        s_reload_hold |=> ##1 !o_watchdog_timeout [*7];
    endproperty
    property p_start_restarts;
        o_reconfig_start |-> o_mode == `RSU_ST_CONFIG;
    endproperty
    property p_status_app;
        $past(i_rd) && $past(i_addr) == `RSU_OFF_STATUS && $past(o_mode) == `RSU_ST_APP
            |-> o_rdata[31:30] == 2'h2 && o_rdata[16:0] == `RSU_WD_LOW;
    endproperty
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 32'h00000000;
    endproperty
    a_core_fires: assert property (p_core_fires)
        else $error("core request did not start an application load");
    a_start_needs_hold: assert property (p_start_needs_hold)
        else $error("application load started without a held request");
    a_error_clears: assert property (p_error_clears)
        else $error("control not cleared on error load");
    a_timeout_start: assert property (p_timeout_start)
        else $error("timeout without factory reconfiguration");
    a_timeout_from_app: assert property (p_timeout_from_app)
        else $error("timeout outside application mode");
    a_timeout_min_count: assert property (p_timeout_min_count)
        else $error("watchdog expired too early");
    a_reload_holds: assert property (p_reload_holds)
        else $error("timeout soon after reload");
    a_start_restarts: assert property (p_start_restarts)
        else $error("reconfiguration did not enter configuration");
    a_status_app: assert property (p_status_app)
        else $error("application status word wrong");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");
endmodule

bind rsu_ctrl rsu_ctrl_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_core_reconfig_request(i_core_reconfig_request),
    .i_watchdog_reload_request(i_watchdog_reload_request),
    .o_reconfig_start(o_reconfig_start), .o_load_app(o_load_app),
    .o_boot_addr(o_boot_addr), .o_early_done_option(o_early_done_option),
    .o_osc_int_option(o_osc_int_option), .o_mode(o_mode),
    .o_watchdog_timeout(o_watchdog_timeout));

// *** verif/rsu_ctrl_tb_top.sv ***
// self-checking bench for the upgrade control block
// assumes rsu_regs.svh on the include path; fabric model drives requests
`timescale 1ns/1ns
`include "rsu_regs.svh"
module rsu_ctrl_tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] e;} rsu_row_t;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0, i_rd = 1'b0, i_crc_error = 1'b0, i_config_done = 1'b0;
    logic i_ext_n = 1'b1, i_sts_n = 1'b1, f;
    logic [31:0] o_rdata;
    logic [23:0] o_boot_addr;
    logic [1:0] o_mode;
    logic o_reconfig_start, o_load_app, o_early, o_osc, o_watchdog_timeout, o_irq;
    logic core_req, rld_req;
    int error_cnt = 0, total_checks = 0, to_cnt = 0;
    rsu_row_t rows [10] = '{'{`RSU_OFF_UPD_CFG, 32'h4}, '{`RSU_OFF_UPD_ADDR, 32'h0},
        '{`RSU_OFF_CTL_CFG, 32'h4}, '{`RSU_OFF_CTL_ADDR, 32'h0}, '{`RSU_OFF_STATUS, 32'h0},
        '{`RSU_OFF_SOURCE, 32'h0}, '{`RSU_OFF_EVT, 32'h0}, '{`RSU_OFF_MASK, 32'h0},
        '{`RSU_OFF_WD_COUNT, 32'h8}, '{8'h24, 32'h0}};
    always #50 i_clk = ~i_clk;
    // timeout pulses counted away from the launching edge
    always @(negedge i_clk) if (o_watchdog_timeout === 1'b1) to_cnt++;
    rsu_fabric_model u_fab (.i_clk(i_clk), .o_core_reconfig_request(core_req),
        .o_watchdog_reload_request(rld_req));
    rsu_ctrl DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_reconfig_request(core_req),
        .i_watchdog_reload_request(rld_req), .i_external_reconfig_pin_n(i_ext_n),
        .i_config_status_pin_n(i_sts_n), .i_crc_error(i_crc_error),
        .i_config_done(i_config_done), .o_reconfig_start(o_reconfig_start),
        .o_load_app(o_load_app), .o_boot_addr(o_boot_addr), .o_early_done_option(o_early),
        .o_osc_int_option(o_osc), .o_mode(o_mode),
        .o_watchdog_timeout(o_watchdog_timeout), .o_irq(o_irq));
    ////////////////////////////////////////////////////////////////////////
    // compare, bus cycles and bounded waits
    task automatic chk_pin(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h", $time, m, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #10 chk_pin(o_rdata, e, m);
    endtask
    task automatic done_pulse();
        @(posedge i_clk);
        i_config_done <= 1'b1;
        @(posedge i_clk);
        i_config_done <= 1'b0;
        #1;
    endtask
    // start is a one-cycle pulse, so look once in every cycle
    task automatic wait_start(input int n, output logic fo);
        fo = 1'b0;
        for (int k = 0; k < n && !fo; k++) begin
            #1;
            fo = (o_reconfig_start === 1'b1);
            if (!fo) @(posedge i_clk);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // hang guard, well beyond the few hundred cycles of the tests
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        foreach (rows[k]) rd_chk(rows[k].a, rows[k].e, "reset value");
        wr(`RSU_OFF_UPD_CFG, 32'h7);
        rd_chk(`RSU_OFF_UPD_CFG, 32'h4, "update locked");
        $display("test reset done");
        done_pulse();
        chk_pin(32'(o_mode), 32'h1, "factory mode");
        wr(`RSU_OFF_UPD_CFG, 32'h7);
        wr(`RSU_OFF_UPD_ADDR, 32'h00123456);
        wr(`RSU_OFF_CTL_CFG, 32'h0);
        wr(`RSU_OFF_MASK, 32'h2);
        rd_chk(`RSU_OFF_UPD_CFG, 32'h7, "update cfg");
        rd_chk(`RSU_OFF_CTL_CFG, 32'h4, "control write");
        u_fab.core_req(2);
        wait_start(6, f);
        chk_pin(32'(f), 32'h0, "short request");
        u_fab.core_req(3);
        wait_start(6, f);
        chk_pin(32'({f, o_load_app, o_early, o_osc, o_boot_addr}), 32'h0f123456, "core");
        rd_chk(`RSU_OFF_CTL_ADDR, 32'h00123456, "control addr");
        rd_chk(`RSU_OFF_SOURCE, 32'h1, "core source");
        wr(`RSU_OFF_EVT, 32'h1);
        rd_chk(`RSU_OFF_EVT, 32'h0, "event clear");
        $display("test core done");
        done_pulse();
        rd_chk(`RSU_OFF_STATUS, 32'ha0000008, "app status");
        wait_start(20, f);
        chk_pin(32'({f, o_watchdog_timeout, o_load_app, o_boot_addr}), 32'h06000000, "exp");
        #10 chk_pin(32'(o_irq), 32'h1, "irq set");
        rd_chk(`RSU_OFF_SOURCE, 32'h2, "wd source");
        wr(`RSU_OFF_EVT, 32'h2);
        #10 chk_pin(32'(o_irq), 32'h0, "irq clear");
        $display("test expiry done");
        done_pulse();
        repeat (20) @(posedge i_clk);
        chk_pin(to_cnt, 32'h1, "factory runs");
        u_fab.core_req(3);
        wait_start(6, f);
        done_pulse();
        repeat (6) u_fab.reload_req(3);
        chk_pin(to_cnt, 32'h1, "reloads");
        wait_start(20, f);
        chk_pin(32'({f, o_watchdog_timeout}), 32'h3, "late expiry");
        $display("test reload done");
        done_pulse();
        u_fab.core_req(3);
        wait_start(6, f);
        @(posedge i_clk);
        i_crc_error <= 1'b1;
        @(posedge i_clk);
        i_crc_error <= 1'b0;
        wait_start(6, f);
        chk_pin(32'({f, o_load_app, o_boot_addr}), 32'h02000000, "crc");
        rd_chk(`RSU_OFF_SOURCE, 32'h8, "crc source");
        @(posedge i_clk);
        i_ext_n <= 1'b0;
        wait_start(8, f);
        chk_pin(32'({f, o_load_app, o_boot_addr}), 32'h02000000, "ext pin");
        @(posedge i_clk);
        i_ext_n <= 1'b1;
        rd_chk(`RSU_OFF_SOURCE, 32'h10, "ext source");
        @(posedge i_clk);
        i_sts_n <= 1'b0;
        wait_start(8, f);
        @(posedge i_clk);
        i_sts_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk_pin(32'({f, o_load_app, o_boot_addr}), 32'h02000000, "status pin");
        rd_chk(`RSU_OFF_SOURCE, 32'h4, "status source");
        $display("test errors done");
        summarize();
    end
endmodule

// *** verif/rsu_fabric_model.sv ***
// fabric user logic that drives the core and reload requests
// assumes it shares i_clk with the upgrade block
`timescale 1ns/1ns
module rsu_fabric_model (
    input wire logic i_clk,
    output logic o_core_reconfig_request,
    output logic o_watchdog_reload_request
);
    initial begin
        o_core_reconfig_request = 1'b0;
        o_watchdog_reload_request = 1'b0;
    end
    // hold for n cycles; fewer than three is too short to act
    task automatic core_req(input int n);
        @(posedge i_clk);
        o_core_reconfig_request <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_core_reconfig_request <= 1'b0;
    endtask
    // next call waits an edge, so a low cycle always separates reloads
    task automatic reload_req(input int n);
        @(posedge i_clk);
        o_watchdog_reload_request <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_watchdog_reload_request <= 1'b0;
    endtask
endmodule
